// ### flash_status_cmd.sv
// How it works
// - Dual data out: four clocks per byte, odd bits on IO1, MSB first.
// - Dual address in: two bits per clock, IO1 odd, A23 first, then mode.
// - Quad data out: two clocks per byte, upper nibble first, bit 7 on IO3.
// - Quad address in: six nibble clocks from A23, then two mode clocks.
// - Quad I/O read waits four don't-care clocks before data nibbles.
// - Quad word read: host keeps A0 zero; only two don't-care clocks.
// - Security areas 1..3 selected by middle byte 10h, 20h, 30h.
// - Wrap bits taken from seventh quad clock: w4 IO0, w5 IO1, w6 IO2.
// - Quad ID read: four dummy clocks, then maker and part code nibbles.
// - Lone write-enable frame sets the write latch flag.
// - Lone write-disable frame clears the write latch flag.
// - Latch flag clears at reset and at end of writes, erases, reset.
// - Status read codes return byte 1, 2 or 3, repeated while clocked.
// - Status reads stay allowed while busy; host should poll busy.
// - Status write accepted only with write latch flag set or after volatile enable.
// - Status write never changes bits 23, 20..15, 1 and 0.
// - Status write runs only if chip select rises right after a byte.
// - Valid non-volatile status write sets busy for the cycle, then clears busy and latch.
// - Bit 8 protects always, bit 7 only while write-protect pin is low; hardware protection refuses writes.
// - Sixteen data bits after 01h write bytes 1 and 2; eight bits write only byte 1 after 01h, only byte 2 after 31h.
// - Volatile enable leaves latch alone and arms a volatile status write.
// - Quad I/O reads run only when quad lane enable bit 9 is set.
// - Mode bits 5..4 equal 10b: next frame starts at address, no command.
`timescale 1ns/1ps
module flash_status_cmd import sfl_pkg::*; #(
   parameter int         TW_CYCLES  = TW_CYC,
   parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value
   parameter logic [7:0] PART_CODE  = 8'h3C  // Arbitrary value
)(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        sclk,
   input  wire logic        cs_b,
   input  wire logic        wp_b,
   input  wire logic [3:0]  io_in,
   input  wire logic        array_done,
   input  wire logic [7:0]  array_byte,
   output logic      [3:0]  io_out_ff,
   output logic      [3:0]  io_oe_ff,
   output logic             busy_progress_flag_ff,
   output logic             write_latch_flag_ff,
   output logic      [23:2] status_ff,
   output logic      [23:0] addr_ff,
   output logic      [7:0]  cmd_ff,
   output logic      [1:0]  sec_area_ff,
   output logic      [2:0]  burst_wrap_bits_ff,
   output logic      [7:0]  continuous_read_bits_ff
);

   if (TW_CYCLES < 1) begin : g_chk
      $error("TW_CYCLES must be at least one");
   end

   // =====================================================================
   // Pin synchronisers and edge detection
   logic [6:0]  pins_s;
   logic [3:0]  io_s;
   logic        sclk_s, cs_b_s, wp_b_s;
   logic        sclk_q_ff, cs_q_ff;
   logic        rise, fall, cs_start, cs_end, act;

   pin_sync #(.W(7), .RST_VAL(7'h20)) u_sync (
      .clk   (mclk),
      .rst_b (rst_b),
      .d     ({wp_b, cs_b, sclk, io_in}),
      .q     (pins_s)
   );

   assign io_s   = pins_s[3:0];
   assign sclk_s = pins_s[4];
   assign cs_b_s = pins_s[5];
   assign wp_b_s = pins_s[6];

   // Previous levels for edge finding
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q_ff <= 1'b0;
         cs_q_ff   <= 1'b1;
      end else begin
         sclk_q_ff <= sclk_s;
         cs_q_ff   <= cs_b_s;
      end
   end

   assign rise     = sclk_s & ~sclk_q_ff;
   assign fall     = ~sclk_s & sclk_q_ff;
   assign cs_start = ~cs_b_s & cs_q_ff;
   assign cs_end   = cs_b_s & ~cs_q_ff;
   assign act      = ~cs_b_s;

   // =====================================================================
   // Frame state
   phase_t      phase_ff;
   logic [31:0] sh_ff, nxt_sh;
   logic [5:0]  cnt_ff, nxt_cnt, edges_ff, alen;
   logic [2:0]  ln_ff, opos_ff;
   logic        idsel_ff, crm_ff, vol_ff, rsten_ff;
   logic [7:0]  crm_cmd_ff, dec_cmd, cur_byte, rot;
   logic [31:0] twc_ff;
   logic        hw_prot, ws_valid, ws_go, frame_one;
   logic [23:0] stat_full, ws_data, ws_merged, nxt_addr;

   assign stat_full = {status_ff, write_latch_flag_ff, busy_progress_flag_ff};
   assign dec_cmd   = {sh_ff[6:0], io_s[0]};
   assign nxt_cnt   = cnt_ff + {3'b000, ln_ff};
   assign alen      = (ln_ff == 3'd1) ? ADDR_BITS : AMODE_BITS;
   // Address as it will be captured; a 24-bit phase has no mode byte below it
   assign nxt_addr  = (alen == AMODE_BITS) ? nxt_sh[31:8] : nxt_sh[23:0];

   // Shift in 1, 2 or 4 lanes; higher lane carries the earlier bit
   always_comb begin
      unique case (ln_ff)
         3'd2:    nxt_sh = {sh_ff[29:0], io_s[1], io_s[0]};
         3'd4:    nxt_sh = {sh_ff[27:0], io_s[3:0]};
         default: nxt_sh = {sh_ff[30:0], io_s[0]};
      endcase
   end

   // Don't-care clocks after address per instruction
   function automatic logic [5:0] dummy_of(input logic [7:0] c);
      unique case (c)
         OP_QIO_RD, OP_QIO_ID:                dummy_of = DUM_QIO;
         OP_QWORD:                            dummy_of = DUM_QWORD;
         OP_FAST_RD, OP_DOUT_RD, OP_QOUT_RD:  dummy_of = DUM_FAST;
         default:                             dummy_of = 6'd0;
      endcase
   endfunction

   // Lanes used for data and for address
   function automatic logic [2:0] dlanes_of(input logic [7:0] c);
      unique case (c)
         OP_QIO_RD, OP_QWORD, OP_QIO_ID, OP_QOUT_RD: dlanes_of = 3'd4;
         OP_DIO_RD, OP_DOUT_RD:                      dlanes_of = 3'd2;
         default:                                    dlanes_of = 3'd1;
      endcase
   endfunction

   // Byte on offer during data output
   always_comb begin
      unique case (cmd_ff)
         OP_STAT1:  cur_byte = stat_full[7:0];
         OP_STAT2:  cur_byte = stat_full[15:8];
         OP_STAT3:  cur_byte = stat_full[23:16];
         OP_QIO_ID: cur_byte = idsel_ff ? PART_CODE : MAKER_CODE;
         default:   cur_byte = array_byte;
      endcase
      rot = cur_byte << opos_ff;
   end

   // =====================================================================
   // Command, address, dummy and data sequencing
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phase_ff                <= PH_IDLE;
         sh_ff                   <= 32'h00000000;
         cnt_ff                  <= 6'd0;
         edges_ff                <= 6'd0;
         ln_ff                   <= 3'd1;
         opos_ff                 <= 3'd0;
         idsel_ff                <= 1'b0;
         cmd_ff                  <= 8'h00;
         addr_ff                 <= 24'h000000;
         sec_area_ff             <= 2'd0;
         crm_ff                  <= 1'b0;
         crm_cmd_ff              <= 8'h00;
         burst_wrap_bits_ff      <= 3'd0;
         continuous_read_bits_ff <= 8'h00;
      end else if (!act) begin
         phase_ff <= PH_IDLE;
         // Reset instruction drops continuous read and wrap
         if (cs_end && cmd_ff == OP_RST && rsten_ff && frame_one) begin
            crm_ff             <= 1'b0;
            burst_wrap_bits_ff <= 3'd0;
         end
      end else if (cs_start) begin
         cnt_ff   <= 6'd0;
         edges_ff <= 6'd0;
         opos_ff  <= 3'd0;
         idsel_ff <= 1'b0;
         if (crm_ff) begin
            // Resume straight at the address phase
            phase_ff <= PH_ADDR;
            cmd_ff   <= crm_cmd_ff;
            ln_ff    <= dlanes_of(crm_cmd_ff);
         end else begin
            phase_ff <= PH_CMD;
            cmd_ff   <= 8'h00;
            ln_ff    <= 3'd1;
         end
      end else if (rise) begin
         if (edges_ff != 6'h3F) begin
            edges_ff <= edges_ff + 6'd1;
         end
         unique case (phase_ff)
            PH_CMD: begin
               sh_ff  <= nxt_sh;
               cnt_ff <= nxt_cnt;
               if (nxt_cnt == CMD_BITS) begin
                  cmd_ff <= dec_cmd;
                  cnt_ff <= 6'd0;
                  // While busy only status reads are served
                  if (busy_progress_flag_ff && dec_cmd != OP_STAT1 &&
                      dec_cmd != OP_STAT2 && dec_cmd != OP_STAT3) begin
                     phase_ff <= PH_SKIP;
                  end else begin
                     unique case (dec_cmd)
                        OP_STAT1, OP_STAT2, OP_STAT3: phase_ff <= PH_DOUT;
                        OP_WSTAT1, OP_WSTAT2:         phase_ff <= PH_DIN;
                        OP_QIO_RD, OP_QWORD, OP_QIO_ID, OP_QOUT_RD: begin
                           phase_ff <= status_ff[BIT_QE] ? PH_ADDR : PH_SKIP;
                           ln_ff    <= (dec_cmd == OP_QOUT_RD) ? 3'd1 : 3'd4;
                        end
                        OP_DIO_RD: begin
                           phase_ff <= PH_ADDR;
                           ln_ff    <= 3'd2;
                        end
                        OP_WRAP: begin
                           phase_ff <= PH_ADDR;
                           ln_ff    <= 3'd4;
                        end
                        OP_READ, OP_FAST_RD, OP_DOUT_RD: phase_ff <= PH_ADDR;
                        default:                         phase_ff <= PH_SKIP;
                     endcase
                  end
               end
            end
            PH_ADDR: begin
               sh_ff  <= nxt_sh;
               cnt_ff <= nxt_cnt;
               if (nxt_cnt == alen) begin
                  cnt_ff <= 6'd0;
                  if (cmd_ff == OP_WRAP) begin
                     burst_wrap_bits_ff <= nxt_sh[WRAP_LSB +: 3];
                     phase_ff           <= PH_SKIP;
                  end else begin
                     if (alen == AMODE_BITS) begin
                        addr_ff                 <= nxt_sh[31:8];
                        continuous_read_bits_ff <= nxt_sh[7:0];
                        crm_cmd_ff              <= cmd_ff;
                        crm_ff                  <= (nxt_sh[5:4] == CRM_KEEP);
                     end else begin
                        addr_ff <= nxt_sh[23:0];
                     end
                     // Middle byte picks a security area when top byte is zero
                     unique case ({nxt_addr[23:16] == 8'h00, nxt_addr[15:8]})
                        {1'b1, SEC_AREA1}: sec_area_ff <= 2'd1;
                        {1'b1, SEC_AREA2}: sec_area_ff <= 2'd2;
                        {1'b1, SEC_AREA3}: sec_area_ff <= 2'd3;
                        default:           sec_area_ff <= 2'd0;
                     endcase
                     ln_ff    <= dlanes_of(cmd_ff);
                     phase_ff <= (dummy_of(cmd_ff) == 6'd0) ? PH_DOUT : PH_DUMMY;
                  end
               end
            end
            PH_DUMMY: begin
               cnt_ff <= cnt_ff + 6'd1;
               if (cnt_ff + 6'd1 == dummy_of(cmd_ff)) begin
                  phase_ff <= PH_DOUT;
               end
            end
            PH_DIN:  sh_ff <= nxt_sh;
            default: ;
         endcase
      end else if (fall && phase_ff == PH_DOUT) begin
         // Advance within the byte; status bytes repeat, others step on
         if (opos_ff + ln_ff == 3'd0) begin
            opos_ff  <= 3'd0;
            idsel_ff <= ~idsel_ff;
            if (cmd_ff != OP_STAT1 && cmd_ff != OP_STAT2 && cmd_ff != OP_STAT3) begin
               addr_ff <= addr_ff + 24'h000001;
            end
         end else begin
            opos_ff <= opos_ff + ln_ff;
         end
      end
   end

   // =====================================================================
   // Output lanes, changed on the falling serial clock
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         io_out_ff <= 4'h0;
         io_oe_ff  <= 4'h0;
      end else if (!act) begin
         io_oe_ff <= 4'h0;
      end else if (fall && phase_ff == PH_DOUT) begin
         unique case (ln_ff)
            3'd4: begin
               io_out_ff <= rot[7:4];
               io_oe_ff  <= 4'hF;
            end
            3'd2: begin
               io_out_ff <= {2'b00, rot[7:6]};
               io_oe_ff  <= 4'h3;
            end
            default: begin
               io_out_ff <= {2'b00, rot[7], 1'b0};
               io_oe_ff  <= 4'h2;
            end
         endcase
      end
   end

   // =====================================================================
   // Status register, write latch and busy timer
   assign frame_one = (edges_ff == CMD_BITS);
   assign hw_prot   = status_ff[BIT_STATUS_PROTECT_HI] | (status_ff[BIT_STATUS_PROTECT_LO] & ~wp_b_s);
   // Write is valid only when chip select rises on a byte boundary
   assign ws_valid  = (phase_ff == PH_DIN) &&
                      ((cmd_ff == OP_WSTAT1 && (edges_ff == EDGES_B1 || edges_ff == EDGES_B12)) ||
                       (cmd_ff == OP_WSTAT2 && edges_ff == EDGES_B1));
   assign ws_go     = cs_end && ws_valid && !hw_prot && !busy_progress_flag_ff &&
                      (write_latch_flag_ff || vol_ff);

   // Place the data bytes; absent bytes keep their old value
   always_comb begin
      ws_data = stat_full;
      if (cmd_ff == OP_WSTAT2) begin
         ws_data[15:8] = sh_ff[7:0];
      end else if (edges_ff == EDGES_B12) begin
         ws_data[7:0]  = sh_ff[15:8];
         ws_data[15:8] = sh_ff[7:0];
      end else begin
         ws_data[7:0] = sh_ff[7:0];
      end
   end

   // Fixed bits keep their value through the mask
   assign ws_merged = (ws_data & STAT_WMASK) | (stat_full & ~STAT_WMASK);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         status_ff             <= STAT_RST[23:2];
         write_latch_flag_ff   <= 1'b0;
         busy_progress_flag_ff <= 1'b0;
         twc_ff                <= 32'h00000000;
         vol_ff                <= 1'b0;
         rsten_ff              <= 1'b0;
      end else begin
         if (busy_progress_flag_ff) begin
            twc_ff <= twc_ff - 32'h00000001;
            if (twc_ff == 32'h00000001) begin
               busy_progress_flag_ff <= 1'b0;
               write_latch_flag_ff   <= 1'b0;
            end
         end
         // Array program and erase completions also drop the latch
         if (array_done) begin
            write_latch_flag_ff <= 1'b0;
         end
         if (cs_end) begin
            vol_ff   <= (cmd_ff == OP_VOL_EN) && frame_one;
            rsten_ff <= (cmd_ff == OP_RST_EN) && frame_one;
            if (!busy_progress_flag_ff && frame_one) begin
               if (cmd_ff == OP_WR_EN) begin
                  write_latch_flag_ff <= 1'b1;
               end
               if (cmd_ff == OP_WR_DIS || (cmd_ff == OP_RST && rsten_ff)) begin
                  write_latch_flag_ff <= 1'b0;
               end
            end
            if (ws_go) begin
               // Busy and latch live outside the stored field
               status_ff <= ws_merged[23:2];
               if (!vol_ff) begin
                  busy_progress_flag_ff <= 1'b1;
                  twc_ff                <= TW_CYCLES;
               end
            end
         end
      end
   end

   // =====================================================================
   // Checks
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_b);

   wel_set_a: assert property (cs_end && cmd_ff == OP_WR_EN && frame_one && !busy_progress_flag_ff
      |=> write_latch_flag_ff) else $error("write enable did not set latch");
   wel_clear_a: assert property (cs_end && cmd_ff == OP_WR_DIS && frame_one && !busy_progress_flag_ff
      && !array_done |=> !write_latch_flag_ff) else $error("write disable left latch set");
   busy_start_a: assert property (ws_go && !vol_ff |=> busy_progress_flag_ff [*3])
      else $error("status write did not hold busy");
   busy_end_a: assert property ($fell(busy_progress_flag_ff) |-> !write_latch_flag_ff)
      else $error("latch still set after status write");
   ws_latch_a: assert property ($rose(busy_progress_flag_ff) |-> $past(write_latch_flag_ff))
      else $error("status write ran without latch");
   fixed_bits_a: assert property (1'b1 |=> (stat_full & STAT_FIXED) == ($past(stat_full) & STAT_FIXED))
      else $error("fixed status bit changed");
   short_write_a: assert property (cs_end && cmd_ff == OP_WSTAT1 && edges_ff == 6'd12
      |=> $stable(status_ff) && !$rose(busy_progress_flag_ff)) else $error("partial write ran");
   hw_prot_a: assert property (cs_end && ws_valid && hw_prot |=> $stable(status_ff))
      else $error("write ran under hardware protection");
   vol_write_a: assert property (ws_go && vol_ff |=> !busy_progress_flag_ff)
      else $error("volatile write set busy");
   vol_latch_a: assert property (cs_end && cmd_ff == OP_VOL_EN && !write_latch_flag_ff
      |=> !write_latch_flag_ff) else $error("volatile enable set latch");
   quad_gate_a: assert property (phase_ff == PH_ADDR && ln_ff == 3'd4 && cmd_ff != OP_WRAP
      |-> status_ff[BIT_QE]) else $error("quad address without quad enable");
   quad_oe_a: assert property (fall && act && phase_ff == PH_DOUT && ln_ff == 3'd4
      |=> io_oe_ff == 4'hF) else $error("quad output not driving all lanes");

   wel_set_c: cover property (cs_end && cmd_ff == OP_WR_EN && frame_one);
   busy_run_c: cover property ($fell(busy_progress_flag_ff));
   crm_resume_c: cover property (cs_start && crm_ff);
   wrap_set_c: cover property (phase_ff == PH_ADDR && cmd_ff == OP_WRAP ##1 phase_ff == PH_SKIP);

endmodule

// ### sfl_pkg.sv
package sfl_pkg;

   // =====================================================================
   // Timing
   localparam int CLK_NS = 8;              // mclk period
   localparam int TW_NS  = 10_000_000;     // Status write cycle, plain default
   localparam int TW_CYC = TW_NS / CLK_NS; // Longest time rounds down

   // =====================================================================
   // Instruction codes
   localparam logic [7:0] OP_WR_EN   = 8'h06;
   localparam logic [7:0] OP_WR_DIS  = 8'h04;
   localparam logic [7:0] OP_VOL_EN  = 8'h50;
   localparam logic [7:0] OP_STAT1   = 8'h05;
   localparam logic [7:0] OP_STAT2   = 8'h35;
   localparam logic [7:0] OP_STAT3   = 8'h15;
   localparam logic [7:0] OP_WSTAT1  = 8'h01;
   localparam logic [7:0] OP_WSTAT2  = 8'h31;
   localparam logic [7:0] OP_WRAP    = 8'h77;
   localparam logic [7:0] OP_QIO_RD  = 8'hEB;
   localparam logic [7:0] OP_QWORD   = 8'hE7;
   localparam logic [7:0] OP_DIO_RD  = 8'hBB;
   localparam logic [7:0] OP_QIO_ID  = 8'h94;
   localparam logic [7:0] OP_DOUT_RD = 8'h3B;
   localparam logic [7:0] OP_QOUT_RD = 8'h6B;
   localparam logic [7:0] OP_FAST_RD = 8'h0B;
   localparam logic [7:0] OP_READ    = 8'h03;
   localparam logic [7:0] OP_RST_EN  = 8'h66;
   localparam logic [7:0] OP_RST     = 8'h99;

   // =====================================================================
   // Status field positions and reset value
   localparam int BIT_STATUS_PROTECT_LO = 7;
   localparam int BIT_STATUS_PROTECT_HI = 8;
   localparam int BIT_QE   = 9;
   localparam logic [23:0] STAT_RST   = 24'h000000;
   localparam logic [23:0] STAT_WMASK = 24'h607FFC; // Writable status bits
   localparam logic [23:0] STAT_FIXED = 24'h9F8000; // Bits 23,20..15 never written

   // =====================================================================
   // Frame lengths in bits and clocks
   localparam logic [5:0] CMD_BITS   = 6'd8;
   localparam logic [5:0] ADDR_BITS  = 6'd24;
   localparam logic [5:0] AMODE_BITS = 6'd32;
   localparam logic [5:0] EDGES_B1   = 6'd16;
   localparam logic [5:0] EDGES_B12  = 6'd24;
   localparam logic [5:0] DUM_QIO    = 6'd4;
   localparam logic [5:0] DUM_QWORD  = 6'd2;
   localparam logic [5:0] DUM_FAST   = 6'd8;
   localparam logic [1:0] CRM_KEEP   = 2'b10;
   localparam int         WRAP_LSB   = 4; // Seventh quad clock lands at [7:4]

   // =====================================================================
   // Security area middle address bytes
   localparam logic [7:0] SEC_AREA1 = 8'h10;
   localparam logic [7:0] SEC_AREA2 = 8'h20;
   localparam logic [7:0] SEC_AREA3 = 8'h30;

   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_CMD   = 3'b001,
      PH_ADDR  = 3'b011,
      PH_DUMMY = 3'b010,
      PH_DOUT  = 3'b110,
      PH_DIN   = 3'b111,
      PH_SKIP  = 3'b101
   } phase_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
)(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);

   // =====================================================================
   // Two flops per bit; the first one feeds only the second
   logic [W-1:0] meta_ff;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            meta_ff[i] <= RST_VAL[i];
            q[i]       <= RST_VAL[i];
         end else begin
            meta_ff[i] <= d[i];
            q[i]       <= meta_ff[i];
         end
      end
   end

endmodule

// ### sfl_host.sv
`timescale 1ns/1ps
module sfl_host (
   output logic            sclk,
   output logic            cs_b,
   output logic [3:0]      io_in,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe
);
   // =========================
   // Idle: clock parked low, lanes show the inverse of their last value
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      io_in = 4'h5;
   end
   // One single-lane frame: MSB first on IO0, IO1 sampled at each rise
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      cs_b = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         io_in[0] = tx[i];
         #62.5 sclk = 1'b1;
         rx = {rx[30:0], io_oe[1] ? io_out[1] : 1'bx};
         #62.5 sclk = 1'b0;
      end
      #62.5 cs_b = 1'b1;
      io_in = ~io_in;
      #250;
   endtask
   // Command on IO0, then nq clocks on four lanes, upper nibble first, its MSB on IO3; lanes read only while driven
   task automatic qframe(input logic [7:0] op, input logic [31:0] tx, input int nq, output logic [31:0] rx);
      rx = '0;
      cs_b = 1'b0;
      for (int i = 0; i < 8 + nq; i++) begin
         io_in = (i < 8) ? {3'b000, op[7 - i]} : (i < 16) ? tx[63 - 4 * i -: 4] : 4'h0;
         #62.5 sclk = 1'b1;
         rx = {rx[27:0], (io_oe == 4'hF) ? io_out : 4'hx};
         #62.5 sclk = 1'b0;
      end
      #62.5 cs_b = 1'b1;
      io_in = ~io_in;
      #250;
   endtask
endmodule

// ### test_flash_status_cmd.sv
`timescale 1ns/1ps
module test_flash_status_cmd import sfl_pkg::*;;
   logic mclk, rst_b, wp_b, sclk, cs_b, busy, write_latch_flag;
   logic [3:0] io_in, io_out, io_oe;
   logic [23:2] st;
   logic [31:0] rx;
   logic [1:0] sec;
   logic [2:0] wrap;
   logic [7:0] crm;
   logic [23:0] addr;
   int n_fail = 0;
   int checked = 0;
   // =========================
   // Clock, pins and the host model
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   sfl_host sfl_host_i (.sclk(sclk), .cs_b(cs_b), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   // Long enough that a status read fits inside the write cycle
   // Identity codes chosen here, arbitrary values
   flash_status_cmd #(.TW_CYCLES(1000), .MAKER_CODE(8'hC3), .PART_CODE(8'h69)) flash_status_cmd_i (
      .mclk(mclk), .rst_b(rst_b), .sclk(sclk),
      .cs_b(cs_b), .wp_b(wp_b), .io_in(io_in), .array_done(1'b0), .array_byte(8'h00), .io_out_ff(io_out),
      .io_oe_ff(io_oe), .busy_progress_flag_ff(busy), .write_latch_flag_ff(write_latch_flag), .status_ff(st),
      .addr_ff(addr), .cmd_ff(), .sec_area_ff(sec), .burst_wrap_bits_ff(wrap), .continuous_read_bits_ff(crm));
   task automatic results();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Start a quarter ns after a falling edge so no pin moves on a rising one
   task automatic send(input logic [31:0] tx, input int n);
      @(negedge mclk);
      #0.25;
      sfl_host_i.frame(tx, n, rx);
   endtask
   task automatic qsend(input logic [7:0] op, input logic [31:0] tx, input int nq);
      @(negedge mclk);
      #0.25;
      sfl_host_i.qframe(op, tx, nq, rx);
   endtask
   // Bounded wait for the end of the self-timed write
   task automatic wait_idle();
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge mclk);
      if (busy !== 1'b0) begin
         n_fail++;
         $display("Error at %0t: busy never cleared", $time);
         results();
      end
   endtask
   task automatic t_latch();
      check({busy, write_latch_flag, st}, 0);
      send(OP_WR_EN, 8);
      check(write_latch_flag, 1);
      send(OP_WR_DIS, 8);
      check(write_latch_flag, 0);
      $display("latch test done");
   endtask
   task automatic t_write();
      send(OP_WR_EN, 8);
      send({OP_WSTAT1, 8'hFF}, 16);
      check(busy, 1);
      send({OP_STAT1, 16'h0}, 24);
      check(rx[15:0], 16'hFFFF);
      wait_idle();
      check({write_latch_flag, st[7:2]}, 7'h3F);
      send({OP_WSTAT1, 16'h00FE}, 24);
      check(st[7:2], 6'h3F);
      send(OP_WR_EN, 8);
      send({OP_WSTAT1, 16'h00FE}, 24);
      wait_idle();
      check(st[15:2], {8'h7E, 6'h00});
      send({OP_STAT2, 8'h0}, 16);
      check(rx[7:0], 8'h7E);
      send({OP_STAT3, 8'h0}, 16);
      check(rx[7:0], 8'h00);
      send(OP_WR_EN, 8);
      send({OP_WSTAT1, 8'h80}, 16);
      wait_idle();
      check(st[15:2], {8'h7E, 6'h20});
      send(OP_WR_EN, 8);
      send({OP_WSTAT1, 4'hA}, 12);
      check({busy, write_latch_flag, st[15:2]}, {2'b01, 8'h7E, 6'h20});
      $display("status write test done");
   endtask
   task automatic t_quad();
      qsend(OP_QIO_ID, {24'h001005, 8'h0C}, 16);
      check(rx[15:0], 16'hC369);
      check({sec, crm}, {2'd1, 8'h0C});
      check(addr, 24'h001007);
      qsend(OP_WRAP, 32'hFFFFFF5F, 8);
      check(wrap, 3'h5);
      $display("quad test done");
   endtask
   task automatic t_protect();
      @(negedge mclk) wp_b = 1'b0;
      send(OP_WR_EN, 8);
      send({OP_WSTAT1, 8'h00}, 16);
      check({busy, st[7:2]}, 7'h20);
      @(negedge mclk) wp_b = 1'b1;
      send(OP_WR_DIS, 8);
      send(OP_VOL_EN, 8);
      send({OP_WSTAT1, 8'h00}, 16);
      check({busy, write_latch_flag, st[7:2]}, 0);
      @(negedge mclk) rst_b = 1'b0;
      @(negedge mclk) rst_b = 1'b1;
      check(st, 0);
      $display("protect and volatile test done");
   endtask
   initial begin
      rst_b = 1'b0;
      wp_b = 1'b1;
      repeat (6) @(posedge mclk);
      @(negedge mclk) rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      t_latch();
      t_write();
      t_quad();
      t_protect();
      results();
   end
endmodule
